// File: core/plb_selftest.sv
`timescale 1ns/1ns
// Operation
// [R1] control bit 14 loops MAC transmit to receive
// [R2] low control bits pick near-end loop points
// [R3] MAC loop reports no link, returns packets
// [R4] MAC loop at 100 reaches line if bit6
// [R5] all loop bits clear means normal operation
// [R6] software disables autonegotiation before internal loops
// [R7] loop points need their listed speed modes
// [R8] MAC loop only with four-bit interface
// [R9] bit 4 returns line receive to line
// [R10] reverse loop feeds MAC, ignores MAC data
// [R11] reverse loop on reduced interface only 10
// [R12] generator sends PRBS15, checker regenerates locally
// [R13] checker counts error bytes in counter register
// [R14] control register shows lock, sync lost, busy
// [R15] bit 14 selects continuous or single counting
// [R16] continuous counter wraps to zero at maximum
// [R17] single counter stops and holds at maximum
// [R18] length register sets generated packet length
// [R19] bit 13 picks constant 64 or 1518 packet
// [R20] packets separated by programmable gaps
// [R21] self-test runs over any loop path; with the reverse loop on, line input replaces generator output
// [R22] registers via management serial, rising clock
// [R23] polynomial x15 plus x14 plus one
// [R24] status bits placed at free positions
module plb_selftest #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // clock and reset
    input  wire logic           mclk_i,
    input  wire logic           rst_b_i,
    // management serial port
    input  wire logic           mdc_i,
    input  wire logic           mdio_i,
    output logic                mdio_o,
    output logic                mdio_oe_b_o,
    // MAC side nibbles
    input  wire plb_pkg::plb_nib_t mac_tx_i,
    output plb_pkg::plb_nib_t      mac_rx_o,
    // line side nibbles
    input  wire plb_pkg::plb_nib_t line_rx_i,
    output plb_pkg::plb_nib_t      line_tx_o,
    // operating status
    input  wire logic           link_up_i,
    input  wire logic           speed_100_i,
    input  wire logic           rmii_mode_i,
    output logic                link_o
);

    plb_pkg::plb_state_t st_reg;
    plb_pkg::plb_state_t st_next;

    logic              autoneg_operation;
    logic              mii_lb;
    logic              rev_lb;
    logic              near_lb;
    logic              run;
    logic              single;
    logic              err_inc;
    logic              run_start;
    plb_pkg::plb_nib_t gen_nib;
    plb_pkg::plb_nib_t tx_path;
    plb_pkg::plb_nib_t rx_path;
    logic [14:0]       gen_step;
    logic [14:0]       chk_step;

    function automatic logic [14:0] prbs4(input logic [14:0] s);
        logic [14:0] r;
        r = s;
        for (int i = 0; i < 4; i++) begin
            r = {r[13:0], r[14] ^ r[13]}; // [R23]
        end
        return r;
    endfunction : prbs4

    assign autoneg_operation   = st_reg.bmc[plb_pkg::BMC_AUTONEG_OPERATION];
    assign mii_lb = st_reg.bmc[plb_pkg::BMC_MII_LB] & ~rmii_mode_i; // [R1] [R7] [R8]
    assign rev_lb = st_reg.slc[plb_pkg::SLC_REVERSE]
                    & ~(rmii_mode_i & speed_100_i); // [R9] [R11]
    assign near_lb =
        (st_reg.slc[plb_pkg::SLC_PCS_IN] & ~autoneg_operation)
        | (st_reg.slc[plb_pkg::SLC_PCS_OUT] & ~autoneg_operation & speed_100_i)
        | (st_reg.slc[plb_pkg::SLC_DIGITAL] & ~autoneg_operation & speed_100_i)
        | (st_reg.slc[plb_pkg::SLC_ANALOG] & (~autoneg_operation | ~speed_100_i)); // [R2] [R5] [R7]
    assign run    = st_reg.slc[plb_pkg::SLC_RUN];
    assign single = st_reg.slc[plb_pkg::SLC_SINGLE];
    assign gen_step = prbs4(st_reg.glfsr); // [R12]
    assign chk_step = prbs4(st_reg.clfsr);

    // generator output of this cycle
    always_comb begin
        gen_nib.en = st_reg.ginpkt;
        gen_nib.d  = single ? plb_pkg::CONST_NIB
                            : gen_step[3:0]; // [R12] [R19]
    end

    // transmit and receive path steering
    always_comb begin
        if (rev_lb) begin
            tx_path = line_rx_i; // [R9] [R10]
        end else if (run) begin
            tx_path = gen_nib; // [R21]
        end else if (mii_lb
                     && !(st_reg.slc[plb_pkg::SLC_MEDIA] && speed_100_i)) begin
            tx_path = '0; // [R4]
        end else begin
            tx_path = mac_tx_i;
        end
        rx_path = near_lb ? tx_path : line_rx_i; // [R2] [R21]
    end

    assign err_inc = run && !single && st_reg.clock && rx_path.en
                     && st_reg.cphase
                     && (st_reg.cberr || chk_step[3:0] != rx_path.d);

    always_comb begin
        logic        rise;
        logic        bitv;
        logic        wr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [11:0] hdr;
        logic [16:0] plen;
        logic [7:0]  gapn;
        logic [14:0] expn;
        st_next = st_reg;
        rise    = st_reg.mdc_s2 & ~st_reg.mdc_s3;
        bitv    = st_reg.mdio_s2;
        wr      = 1'b0;
        wdata   = {st_reg.mshift[14:0], bitv};
        rdata   = 16'h0000;
        hdr     = {st_reg.mshift[10:0], bitv};
        plen    = '0;
        gapn    = '0;
        expn    = chk_step;
        run_start = 1'b0;

        st_next.mdc_s1  = mdc_i;
        st_next.mdc_s2  = st_reg.mdc_s1;
        st_next.mdc_s3  = st_reg.mdc_s2;
        st_next.mdio_s1 = mdio_i;
        st_next.mdio_s2 = st_reg.mdio_s1;

        case (st_reg.mreg)
            plb_pkg::REG_BMC: rdata = st_reg.bmc;
            plb_pkg::REG_SLC: begin
                rdata = st_reg.slc;
                rdata[plb_pkg::SLC_LOCK]      = st_reg.clock; // [R14] [R24]
                rdata[plb_pkg::SLC_SYNC_LOST] = st_reg.csyncl;
                rdata[plb_pkg::SLC_BUSY]      = (run & ~st_reg.gdone)
                                                | (st_reg.ggap != 8'h00);
            end
            plb_pkg::REG_ERR: rdata = st_reg.errc; // [R13]
            plb_pkg::REG_LEN: rdata = st_reg.len;
            default:          rdata = 16'h0000;
        endcase

        // management frame, sampled on the rising clock
        if (rise) begin // [R22]
            unique case (st_reg.mst)
                plb_pkg::M_PRE: begin
                    if (bitv) begin
                        if (st_reg.mcnt != plb_pkg::PRE_BITS) begin
                            st_next.mcnt = st_reg.mcnt + 6'h01;
                        end
                    end else if (st_reg.mcnt == plb_pkg::PRE_BITS) begin
                        st_next.mst = plb_pkg::M_ST;
                    end else begin
                        st_next.mcnt = 6'h00;
                    end
                end
                plb_pkg::M_ST: begin
                    st_next.mcnt = 6'h00;
                    st_next.mst  = bitv ? plb_pkg::M_HDR : plb_pkg::M_PRE;
                end
                plb_pkg::M_HDR: begin
                    st_next.mshift = {st_reg.mshift[14:0], bitv};
                    st_next.mcnt   = st_reg.mcnt + 6'h01;
                    if (st_reg.mcnt == 6'h0B) begin
                        st_next.mst  = plb_pkg::M_TA;
                        st_next.mcnt = 6'h00;
                        st_next.mrd  = hdr[11:10] == 2'b10;
                        st_next.mok  = (hdr[11] ^ hdr[10])
                                       && hdr[9:5] == PHY_ADDR;
                        st_next.mreg = hdr[4:0];
                    end
                end
                plb_pkg::M_TA: begin
                    st_next.mcnt = st_reg.mcnt + 6'h01;
                    if (st_reg.mrd && st_reg.mok) begin
                        st_next.mdoe_b = 1'b0;
                        st_next.mdo    = st_reg.mcnt[0] ? rdata[15] : 1'b0;
                        st_next.mshift = rdata;
                    end
                    if (st_reg.mcnt[0]) begin
                        st_next.mst  = plb_pkg::M_DAT;
                        st_next.mcnt = 6'h00;
                    end
                end
                plb_pkg::M_DAT: begin
                    st_next.mcnt = st_reg.mcnt + 6'h01;
                    if (st_reg.mrd) begin
                        st_next.mshift = {st_reg.mshift[14:0], 1'b0};
                        st_next.mdo    = st_reg.mshift[14];
                    end else begin
                        st_next.mshift = wdata;
                    end
                    if (st_reg.mcnt == 6'h0F) begin
                        st_next.mdoe_b = 1'b1;
                        st_next.mst    = plb_pkg::M_PRE;
                        st_next.mcnt   = 6'h00;
                        wr = ~st_reg.mrd & st_reg.mok;
                    end
                end
            endcase
        end

        // register writes
        if (wr) begin
            case (st_reg.mreg)
                plb_pkg::REG_BMC: st_next.bmc = wdata;
                plb_pkg::REG_SLC: begin
                    st_next.slc = wdata & plb_pkg::SLC_WMASK;
                    run_start   = wdata[plb_pkg::SLC_RUN] & ~run;
                end
                plb_pkg::REG_LEN: st_next.len = wdata; // [R18]
                default: ;
            endcase
        end

        // packet generator
        plen = {(single ? (st_reg.slc[plb_pkg::SLC_SIZE] ? plb_pkg::LONG_PKT
                                                        : plb_pkg::SHORT_PKT)
                        : st_reg.len), 1'b0}; // [R18] [R19]
        gapn = plb_pkg::BASE_GAP_NIB
               << st_reg.slc[plb_pkg::SLC_GAP_LO +: 2]; // [R20]
        if (!run || run_start) begin
            st_next.ginpkt = 1'b0;
            st_next.ggap   = 8'h00;
            st_next.gdone  = 1'b0;
        end else if (st_reg.ginpkt) begin
            st_next.gcnt = st_reg.gcnt + 17'h00001;
            if (!single) begin
                st_next.glfsr = gen_step; // [R12]
            end
            if (st_reg.gcnt + 17'h00001 >= plen) begin
                st_next.ginpkt = 1'b0;
                // the cycle at zero is the last gap cycle
                st_next.ggap   = gapn - 8'h01; // [R20]
                st_next.gdone  = single; // [R19]
            end
        end else if (st_reg.ggap != 8'h00) begin
            st_next.ggap = st_reg.ggap - 8'h01;
        end else if (!st_reg.gdone) begin
            st_next.ginpkt = 1'b1;
            st_next.gcnt   = 17'h00000;
        end

        // checker
        if (run_start) begin
            st_next.clock  = 1'b0;
            st_next.cmatch = 4'h0;
            st_next.cmiss  = 3'h0;
            st_next.cphase = 1'b0;
            st_next.cberr  = 1'b0;
            st_next.errc   = 16'h0000;
            st_next.csyncl = 1'b0;
        end else if (run && !single && rx_path.en) begin
            if (!st_reg.clock) begin
                st_next.clfsr = {st_reg.clfsr[10:0], rx_path.d};
                st_next.cmatch = (expn[3:0] == rx_path.d)
                                 ? st_reg.cmatch + 4'h1 : 4'h0;
                if (st_next.cmatch == plb_pkg::LOCK_NIB) begin
                    st_next.clock  = 1'b1; // [R14]
                    st_next.cphase = 1'b0;
                    st_next.cberr  = 1'b0;
                    st_next.cmiss  = 3'h0;
                end
            end else begin
                st_next.clfsr  = expn; // [R12]
                st_next.cphase = ~st_reg.cphase;
                if (expn[3:0] != rx_path.d) begin
                    st_next.cberr = 1'b1;
                    st_next.cmiss = st_reg.cmiss + 3'h1;
                end else begin
                    st_next.cmiss = 3'h0;
                end
                if (st_reg.cphase) begin
                    st_next.cberr = 1'b0;
                end
                if (err_inc) begin // [R13]
                    if (st_reg.errc != 16'hFFFF) begin
                        st_next.errc = st_reg.errc + 16'h0001;
                    end else if (!st_reg.slc[plb_pkg::SLC_CMODE]) begin
                        st_next.errc = 16'h0000; // [R15] [R16]
                    end // [R17]
                end
                if (st_next.cmiss == plb_pkg::LOSS_NIB) begin
                    st_next.clock  = 1'b0;
                    st_next.cmatch = 4'h0;
                    st_next.csyncl = 1'b1; // [R14]
                end
            end
        end

        // registered pin outputs
        st_next.mac_rx  = mii_lb ? mac_tx_i : rx_path; // [R1] [R3] [R10]
        st_next.line_tx = near_lb ? '0 : tx_path; // [R4] [R9]
        st_next.link    = link_up_i & ~mii_lb; // [R3]
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st_reg        <= '0;
            st_reg.mdoe_b <= 1'b1;
            st_reg.bmc    <= plb_pkg::BMC_RST;
            st_reg.slc    <= plb_pkg::SLC_RST;
            st_reg.len    <= plb_pkg::LEN_RST;
            st_reg.glfsr  <= plb_pkg::PRBS_SEED;
        end else begin
            st_reg <= st_next;
        end
    end

    assign mdio_o      = st_reg.mdo;
    assign mdio_oe_b_o = st_reg.mdoe_b;
    assign mac_rx_o    = st_reg.mac_rx;
    assign line_tx_o   = st_reg.line_tx;
    assign link_o      = st_reg.link;

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_gen_start;
        $rose(line_tx_o.en) && run && !rev_lb;
    endsequence

    property p_mii_loop;
        mii_lb && mac_tx_i.en |=> mac_rx_o.en
                                  && mac_rx_o.d == $past(mac_tx_i.d);
    endproperty
    a_mii_loop: assert property (p_mii_loop) // [R1]
        else $error("mac loop did not return data");

    property p_no_link;
        mii_lb |=> !link_o;
    endproperty
    a_no_link: assert property (p_no_link) // [R3]
        else $error("link shown during mac loop");

    property p_media;
        mii_lb && !run && !rev_lb && !near_lb
        && !(st_reg.slc[plb_pkg::SLC_MEDIA] && speed_100_i)
        |=> !line_tx_o.en;
    endproperty
    a_media: assert property (p_media) // [R4]
        else $error("mac loop data reached line");

    property p_reverse;
        rev_lb && !near_lb |=> line_tx_o == $past(line_rx_i);
    endproperty
    a_reverse: assert property (p_reverse) // [R9]
        else $error("reverse loop did not return line data");

    property p_rev_mac;
        rev_lb && !near_lb && !mii_lb |=> mac_rx_o == $past(line_rx_i);
    endproperty
    a_rev_mac: assert property (p_rev_mac) // [R10]
        else $error("reverse loop did not feed mac");

    property p_wrap;
        err_inc && !run_start && st_reg.errc == 16'hFFFF
        && !st_reg.slc[plb_pkg::SLC_CMODE] |=> st_reg.errc == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) // [R16]
        else $error("continuous counter did not wrap");

    property p_hold;
        st_reg.errc == 16'hFFFF && st_reg.slc[plb_pkg::SLC_CMODE]
        && !run_start |=> st_reg.errc == 16'hFFFF;
    endproperty
    a_hold: assert property (p_hold) // [R17]
        else $error("single counter left maximum");

    property p_const_pkt;
        s_gen_start ##0 single |-> line_tx_o.d == plb_pkg::CONST_NIB;
    endproperty
    a_const_pkt: assert property (p_const_pkt) // [R19]
        else $error("single packet data not constant");

endmodule : plb_selftest

// File: include/plb_pkg.sv
package plb_pkg;

    // management register map
    localparam logic [4:0]  REG_BMC       = 5'h00;
    localparam logic [4:0]  REG_SLC       = 5'h16;
    localparam logic [4:0]  REG_ERR       = 5'h1B;
    localparam logic [4:0]  REG_LEN       = 5'h1C;

    // basic_mode_control fields
    localparam int          BMC_MII_LB    = 14;
    localparam int          BMC_AUTONEG_OPERATION      = 12;

    // selftest_loop_control fields
    localparam int          SLC_PCS_IN    = 0;
    localparam int          SLC_PCS_OUT   = 1;
    localparam int          SLC_DIGITAL   = 2;
    localparam int          SLC_ANALOG    = 3;
    localparam int          SLC_REVERSE   = 4;
    localparam int          SLC_MEDIA     = 6;
    localparam int          SLC_GAP_LO    = 7;
    localparam int          SLC_LOCK      = 9;
    localparam int          SLC_SYNC_LOST = 10;
    localparam int          SLC_BUSY      = 11;
    localparam int          SLC_SINGLE    = 12;
    localparam int          SLC_SIZE      = 13;
    localparam int          SLC_CMODE     = 14;
    localparam int          SLC_RUN       = 15;
    localparam logic [15:0] SLC_WMASK     = 16'hF1DF;

    // reset values
    localparam logic [15:0] BMC_RST       = 16'h1000;
    localparam logic [15:0] SLC_RST       = 16'h0000;
    localparam logic [15:0] LEN_RST       = 16'h0040;
    localparam logic [14:0] PRBS_SEED     = 15'h7FFF;

    // generator, checker and management frame figures
    localparam logic [15:0] SHORT_PKT     = 16'h0040;
    localparam logic [15:0] LONG_PKT      = 16'h05EE;
    localparam logic [7:0]  BASE_GAP_NIB  = 8'h18;
    localparam logic [3:0]  CONST_NIB     = 4'h5;
    localparam logic [3:0]  LOCK_NIB      = 4'h8;
    localparam logic [2:0]  LOSS_NIB      = 3'h4;
    localparam logic [5:0]  PRE_BITS      = 6'h20;

    // management frame states
    typedef enum logic [2:0] {
        M_PRE = 3'b000,
        M_ST  = 3'b001,
        M_HDR = 3'b011,
        M_TA  = 3'b010,
        M_DAT = 3'b110
    } plb_mstate_t;

    typedef struct packed {
        logic       en;
        logic [3:0] d;
    } plb_nib_t;

    typedef struct packed {
        logic        mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
        plb_mstate_t mst;
        logic [5:0]  mcnt;
        logic [15:0] mshift;
        logic        mrd, mok, mdo, mdoe_b;
        logic [4:0]  mreg;
        logic [15:0] bmc, slc, len, errc;
        logic        ginpkt, gdone;
        logic [16:0] gcnt;
        logic [7:0]  ggap;
        logic [14:0] glfsr, clfsr;
        logic        clock, cphase, cberr, csyncl;
        logic [3:0]  cmatch;
        logic [2:0]  cmiss;
        plb_nib_t    mac_rx, line_tx;
        logic        link;
    } plb_state_t;

endpackage : plb_pkg

// File: dv/plb_mac_model.sv
`timescale 1ns/1ns
module plb_mac_model (
    // clock
    input  wire logic         mclk_i,
    // nibbles toward the device
    output plb_pkg::plb_nib_t mac_tx_o
);
    initial mac_tx_o = '0;

    // one nibble per cycle, launched just after the edge
    task drive(input logic en, input logic [3:0] d);
        @(posedge mclk_i);
        #1;
        mac_tx_o.en = en;
        // released data turns over so a stale nibble never passes
        mac_tx_o.d  = en ? d : ~mac_tx_o.d;
    endtask : drive
endmodule : plb_mac_model

// File: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam logic [4:0]  PHY = 5'h03;
    localparam logic [4:0]  SLC = plb_pkg::REG_SLC;
    localparam logic [4:0]  RA [5] = '{plb_pkg::REG_BMC, plb_pkg::REG_SLC,
        plb_pkg::REG_LEN, plb_pkg::REG_ERR, 5'h05};
    localparam logic [15:0] RV [5] = '{plb_pkg::BMC_RST, plb_pkg::SLC_RST,
        plb_pkg::LEN_RST, 16'h0000, 16'h0000};
    logic              mclk_i;
    logic              rst_b_i;
    logic              mdc_i;
    logic              st_en;
    logic              st_d;
    logic              mdio_o;
    logic              mdio_oe_b_o;
    logic              mdio_w;
    plb_pkg::plb_nib_t mac_tx;
    plb_pkg::plb_nib_t mac_rx_o;
    plb_pkg::plb_nib_t lrx;
    plb_pkg::plb_nib_t line_rx_i;
    plb_pkg::plb_nib_t line_tx_o;
    logic              fix;
    logic [3:0]        cor;
    logic              link_up_i;
    logic              speed_100_i;
    logic              rmii_mode_i;
    logic              link_o;
    logic [15:0]       q;
    int                bad_count;
    int                checks_done;
    int                n;
    int                g;
    int                k;

    // wire level, pulled up while nobody drives
    assign mdio_w = !mdio_oe_b_o ? mdio_o : (st_en ? st_d : 1'b1);
    // external fixture joins line output back to line input
    assign line_rx_i = fix ? {line_tx_o.en, line_tx_o.d ^ cor} : lrx;

    plb_selftest #(.PHY_ADDR(PHY)) plb_selftest_inst (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .mdc_i(mdc_i), .mdio_i(mdio_w),
        .mdio_o(mdio_o), .mdio_oe_b_o(mdio_oe_b_o), .mac_tx_i(mac_tx),
        .mac_rx_o(mac_rx_o), .line_rx_i(line_rx_i), .line_tx_o(line_tx_o),
        .link_up_i(link_up_i), .speed_100_i(speed_100_i),
        .rmii_mode_i(rmii_mode_i), .link_o(link_o));
    plb_mac_model plb_mac_model_inst (.mclk_i(mclk_i), .mac_tx_o(mac_tx));

    initial mclk_i = 1'b0;
    always #25 mclk_i = ~mclk_i;

    task tick;
        @(posedge mclk_i);
        #1;
    endtask : tick

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // one management bit: data set while clock low, wire sampled at rise
    task mbit(input logic drv, input logic b, output logic r);
        st_en = drv;
        st_d  = b;
        repeat (4) tick;
        r     = mdio_w;
        mdc_i = 1'b1;
        repeat (4) tick;
        mdc_i = 1'b0;
    endtask : mbit

    task frame(input logic [4:0] pa, input logic rd, input logic [4:0] ra,
               input logic [15:0] wd, output logic [15:0] rq);
        logic [13:0] hd;
        logic        r;
        hd = {2'b01, rd ? 2'b10 : 2'b01, pa, ra};
        for (int i = 0; i < 32; i++) mbit(1'b1, 1'b1, r);
        for (int i = 13; i >= 0; i--) mbit(1'b1, hd[i], r);
        mbit(!rd, 1'b1, r);
        mbit(!rd, 1'b0, r);
        if (rd) chk({15'h0000, r}, 16'h0000);
        for (int i = 15; i >= 0; i--) begin
            mbit(!rd, wd[i], r);
            rq[i] = r;
        end
        st_en = 1'b0;
        repeat (4) tick;
    endtask : frame

    task wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] x;
        frame(PHY, 1'b0, ra, d, x);
    endtask : wr

    task rchk(input logic [4:0] ra, input logic [15:0] exp);
        frame(PHY, 1'b1, ra, 16'h0000, q);
        chk(q, exp);
    endtask : rchk

    // stream nibbles both sides; 0 = from MAC, 1 = from line, 2 = quiet
    task pump(input int rs, input int ts);
        plb_pkg::plb_nib_t pm;
        plb_pkg::plb_nib_t pl;
        plb_pkg::plb_nib_t ex;
        for (int i = 0; i <= 6; i++) begin
            plb_mac_model_inst.drive(1'b1, i[3:0]);
            lrx = {1'b1, ~i[3:0]};
            if (i > 0) begin
                ex = rs == 0 ? pm : pl;
                chk({11'h000, mac_rx_o}, {11'h000, ex});
                ex = ts == 0 ? pm : (ts == 1 ? pl : '0);
                chk({11'h000, line_tx_o}, {11'h000, ex});
            end
            pm = {1'b1, i[3:0]};
            pl = {1'b1, ~i[3:0]};
        end
        plb_mac_model_inst.drive(1'b0, 4'h0);
        lrx = {1'b0, ~lrx.d};
    endtask : pump

    // packet nibbles, non-constant nibbles, then gap up to next packet
    task meas(output int pn, output int pg, output int pk);
        int w;
        pn = 0;
        pg = 0;
        pk = 0;
        w  = 0;
        while (line_tx_o.en !== 1'b1 && w < 9000) begin
            tick;
            w++;
        end
        while (line_tx_o.en === 1'b1 && pn < 4000) begin
            pn++;
            if (line_tx_o.d !== plb_pkg::CONST_NIB) pk++;
            tick;
        end
        while (line_tx_o.en !== 1'b1 && pg < 400) begin
            tick;
            pg++;
        end
    endtask : meas

    initial begin
        repeat (60000) @(posedge mclk_i);
        bad_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_sim;
    end

    initial begin
        bad_count = 0;
        checks_done = 0;
        rst_b_i = 1'b0;
        mdc_i = 1'b0;
        st_en = 1'b0;
        st_d = 1'b0;
        lrx = '0;
        fix = 1'b0;
        cor = 4'h0;
        link_up_i = 1'b1;
        speed_100_i = 1'b1;
        rmii_mode_i = 1'b0;
        repeat (2) tick;
        rst_b_i = 1'b1;
        repeat (2) tick;
        wr(5'h05, 16'hFFFF);
        for (int i = 0; i < 5; i++) rchk(RA[i], RV[i]);
        wr(SLC, 16'h0E2F);
        rchk(SLC, 16'h000F);
        wr(plb_pkg::REG_ERR, 16'h1234);
        rchk(plb_pkg::REG_ERR, 16'h0000);
        frame(5'h04, 1'b0, plb_pkg::REG_LEN, 16'h0022, q);
        rchk(plb_pkg::REG_LEN, plb_pkg::LEN_RST);
        wr(SLC, 16'h0000);
        $display("test registers done");
        wr(plb_pkg::REG_BMC, 16'h4000);
        pump(0, 2);
        chk({15'h0000, link_o}, 16'h0000);
        wr(SLC, 16'h0040);
        pump(0, 0);
        speed_100_i = 1'b0;
        pump(0, 2);
        speed_100_i = 1'b1;
        rmii_mode_i = 1'b1;
        pump(1, 0);
        chk({15'h0000, link_o}, 16'h0001);
        rmii_mode_i = 1'b0;
        wr(SLC, 16'h0000);
        wr(plb_pkg::REG_BMC, 16'h0000);
        $display("test interface loop done");
        for (int i = 0; i < 4; i++) begin
            wr(SLC, 16'h0001 << i);
            pump(0, 2);
        end
        wr(plb_pkg::REG_BMC, plb_pkg::BMC_RST);
        wr(SLC, 16'h0002);
        pump(1, 0);
        wr(plb_pkg::REG_BMC, 16'h0000);
        wr(SLC, 16'h0000);
        pump(1, 0);
        $display("test near loops done");
        wr(SLC, 16'h0010);
        pump(1, 1);
        rmii_mode_i = 1'b1;
        pump(1, 0);
        speed_100_i = 1'b0;
        pump(1, 1);
        rmii_mode_i = 1'b0;
        speed_100_i = 1'b1;
        wr(SLC, 16'h0000);
        $display("test reverse loop done");
        fix = 1'b1;
        wr(plb_pkg::REG_LEN, 16'h0010);
        fork
            wr(SLC, 16'h8100);
            meas(n, g, k);
        join
        chk(n[15:0], 16'h0020);
        chk(g[15:0], 16'h0060);
        for (int j = 0; j < 3; j++) begin
            repeat (7) tick;
            cor = 4'hF;
            tick;
            cor = 4'h0;
        end
        rchk(plb_pkg::REG_ERR, 16'h0003);
        frame(PHY, 1'b1, SLC, 16'h0000, q);
        chk(q & 16'h0E00, 16'h0A00);
        meas(n, g, k);
        repeat (2) tick;
        cor = 4'hF;
        repeat (6) tick;
        cor = 4'h0;
        frame(PHY, 1'b1, SLC, 16'h0000, q);
        chk(q & 16'h0400, 16'h0400);
        wr(SLC, 16'h0000);
        $display("test generator done");
        for (int s = 0; s < 2; s++) begin
            fork
                wr(SLC, s == 1 ? 16'hB000 : 16'h9000);
                meas(n, g, k);
            join
            chk(n[15:0], s == 1 ? 16'h0BDC : 16'h0080);
            chk(k[15:0], 16'h0000);
            chk(g[15:0], 16'h0190);
            wr(SLC, 16'h0000);
        end
        $display("test single packet done");
        end_sim;
    end
endmodule : tb_top
